// ==== bwcr_pkg.sv ====
// shared constants and carrier types of the bridge window configuration registers
package bwcr_pkg;

    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_PF_WIN = 8'h24;
    localparam logic [7:0] OFF_PF_BOT_HI = 8'h28;
    localparam logic [7:0] OFF_PF_TOP_HI = 8'h2C;
    localparam logic [7:0] OFF_IO_HI = 8'h30;
    localparam logic [7:0] OFF_CAP_PTR = 8'h34;
    localparam logic [7:0] OFF_IRQ_LINE = 8'h3C;

    // ------------------------------------------------------------------
    // field layout
    // ------------------------------------------------------------------
    localparam int PF_BOT_LSB = 4;
    localparam int PF_TOP_LSB = 20;
    localparam int PF_FIELD_W = 12;
    localparam int PF_TYPE_BOT_LSB = 0;
    localparam int PF_TYPE_TOP_LSB = 16;
    localparam int IO_BOT_LSB = 0;
    localparam int IO_TOP_LSB = 16;
    localparam int IO_FIELD_W = 16;
    localparam int IRQ_LINE_W = 8;
    localparam int CAP_PTR_W = 8;
    localparam logic [3:0] PF_TYPE_64 = 4'h1;
    localparam logic [19:0] PF_LOW_ZERO = 20'h00000;
    localparam logic [19:0] PF_LOW_ONES = 20'hFFFFF;

    // ------------------------------------------------------------------
    // write masks and reset values
    // ------------------------------------------------------------------
    localparam logic [31:0] MASK_PF_WIN = 32'hFFF0FFF0;
    localparam logic [31:0] MASK_FULL = 32'hFFFFFFFF;
    localparam logic [31:0] MASK_IRQ_LINE = 32'h000000FF;
    localparam logic [31:0] RST_ZERO = 32'h00000000;
    localparam logic [7:0] CAP_PTR_VAL = 8'h40;
    localparam logic [31:0] RD_UNMAPPED = 32'h00000000;

    // ------------------------------------------------------------------
    // carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [63:0] bottom;
        logic [63:0] top;
    } bwcr_pf_win_t;

    typedef struct packed {
        logic [31:0] bottom;
        logic [31:0] top;
    } bwcr_io_win_t;

    typedef struct packed {
        logic vld;
        logic wr;
        logic [63:0] addr;
    } bwcr_mem_req_t;

    typedef struct packed {
        logic vld;
        logic wr;
        logic [31:0] addr;
    } bwcr_io_req_t;

    typedef struct packed {
        logic vld;
        logic wr;
        logic hit;
    } bwcr_fwd_t;

endpackage

// ==== bwcr_wr_reg.sv ====
// one 32-bit configuration word with byte-lane writes and a writable-bit mask
`timescale 1ns/100ps
module bwcr_wr_reg #(
    parameter logic [31:0] RST_VAL = 32'h00000000,
    parameter logic [31:0] WR_MASK = 32'hFFFFFFFF
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // write port
    input wire logic wr_en_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] wdat_i,
    // stored value
    output logic [31:0] q_o
);

    logic [31:0] q_q;
    logic [31:0] q_d;
    wire [31:0] lane_mask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
    wire [31:0] wr_bits = lane_mask & WR_MASK;

    assign q_d = wr_en_i ? ((q_q & ~wr_bits) | (wdat_i & wr_bits)) : q_q;
    assign q_o = q_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q_q <= RST_VAL;
        end else begin
            q_q <= q_d;
        end
    end

endmodule // bwcr_wr_reg

// ==== bwcr_win_cmp.sv ====
// inclusive address window compare, empty when bottom is above top
`timescale 1ns/100ps
module bwcr_win_cmp #(
    parameter int AW = 64
) (
    // window
    input wire logic [AW-1:0] bottom_i,
    input wire logic [AW-1:0] top_i,
    // address under test
    input wire logic [AW-1:0] addr_i,
    // result
    output logic hit_o
);

    wire win_open = (bottom_i <= top_i);
    wire above_bot = (addr_i >= bottom_i);
    wire below_top = (addr_i <= top_i);

    assign hit_o = win_open && above_bot && below_top;

endmodule // bwcr_win_cmp

// ==== bwcr_regs.sv ====
// bridge window configuration registers with Wishbone slave and window decode
`timescale 1ns/100ps

// Notes on behaviour
// R1: the low nibble of the prefetchable bottom and top fields reads 0001b and ignores writes.
// R2: bottom field bits 15:4 give window bottom address bits 31:20, low 20 bits taken as zero.
// R3: top field bits 31:20 give window top address bits 31:20, low 20 bits taken as all ones.
// R4: the word at 28h holds bottom address bits 63:32, joined into a 64-bit bottom.
// R5: the word at 2Ch holds top address bits 63:32, joined into a 64-bit top.
// R6: the 64-bit prefetchable window decides whether a memory request is forwarded.
// R7: bits 15:0 at 30h give bits 31:16 of the I/O window bottom used for forwarding.
// R8: bits 31:16 at 30h give bits 31:16 of the I/O window top used for forwarding.
// R9: every writable window field, upper words included, resets to zero.
// R10: the capability pointer is read-only and reads 40h.
// R11: the interrupt line byte at 3Ch is free read/write storage resetting to 00h.
// R12: window compares are inclusive at both ends and an inverted window matches nothing.
module bwcr_regs #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // low half of the i/o window, held by the i/o base and limit registers
    input wire logic [15:0] io_bot_low_i,
    input wire logic [15:0] io_top_low_i,
    // forwarding requests
    input wire bwcr_pkg::bwcr_mem_req_t mem_req_i,
    input wire bwcr_pkg::bwcr_io_req_t io_req_i,
    // forwarding decisions
    output bwcr_pkg::bwcr_fwd_t mem_fwd_o,
    output bwcr_pkg::bwcr_fwd_t io_fwd_o,
    // assembled windows
    output bwcr_pkg::bwcr_pf_win_t pf_win_o,
    output bwcr_pkg::bwcr_io_win_t io_win_o,
    output logic [7:0] irq_line_o
);

    // ------------------------------------------------------------------
    // parameter check
    // ------------------------------------------------------------------
    generate
        if (ADDR_W < 8) begin : g_bad_addr_w
            $error("bwcr_regs: ADDR_W must be at least 8");
        end
        // fields must tile the words exactly, or the decode reads the wrong bits
        if (bwcr_pkg::PF_BOT_LSB + bwcr_pkg::PF_FIELD_W
                > bwcr_pkg::PF_TYPE_TOP_LSB) begin : g_bad_pf_bot
            $error("bwcr_regs: prefetch bottom field runs into the top type nibble");
        end
        if (bwcr_pkg::PF_TOP_LSB + bwcr_pkg::PF_FIELD_W != 32) begin : g_bad_pf_top
            $error("bwcr_regs: prefetch top field must end at bit 31");
        end
        if (bwcr_pkg::PF_FIELD_W + $bits(bwcr_pkg::PF_LOW_ZERO) != 32) begin : g_bad_pf_fill
            $error("bwcr_regs: prefetch field and low fill must make 32 bits");
        end
        if (bwcr_pkg::IO_BOT_LSB + bwcr_pkg::IO_FIELD_W
                > bwcr_pkg::IO_TOP_LSB) begin : g_bad_io_bot
            $error("bwcr_regs: i/o bottom half runs into the top half");
        end
        if (bwcr_pkg::IO_TOP_LSB + bwcr_pkg::IO_FIELD_W != 32) begin : g_bad_io_top
            $error("bwcr_regs: i/o top half must end at bit 31");
        end
        if (bwcr_pkg::IRQ_LINE_W != $bits(irq_line_o)) begin : g_bad_irq_w
            $error("bwcr_regs: interrupt line width must match its output");
        end
        if (bwcr_pkg::CAP_PTR_W != $bits(bwcr_pkg::CAP_PTR_VAL)) begin : g_bad_cap_w
            $error("bwcr_regs: capability pointer width must match its value");
        end
    endgenerate

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
        logic upper_zero;
        upper_zero = ((a >> 8) == '0);
        reg_hit = upper_zero && (a[7:2] == off[7:2]);
    endfunction

    logic ack_q;
    logic [31:0] rdat_q;

    wire bus_req = wb_cyc_i && wb_stb_i;
    wire bus_start = bus_req && !ack_q;
    // a write lands on the edge that samples ack, as the master expects
    wire bus_wr = bus_req && wb_we_i && ack_q;

    wire hit_pf_win = reg_hit(wb_adr_i, bwcr_pkg::OFF_PF_WIN);
    wire hit_pf_bot_hi = reg_hit(wb_adr_i, bwcr_pkg::OFF_PF_BOT_HI);
    wire hit_pf_top_hi = reg_hit(wb_adr_i, bwcr_pkg::OFF_PF_TOP_HI);
    wire hit_io_hi = reg_hit(wb_adr_i, bwcr_pkg::OFF_IO_HI);
    wire hit_cap_ptr = reg_hit(wb_adr_i, bwcr_pkg::OFF_CAP_PTR);
    wire hit_irq_line = reg_hit(wb_adr_i, bwcr_pkg::OFF_IRQ_LINE);

    // ------------------------------------------------------------------
    // register words
    // ------------------------------------------------------------------
    logic [31:0] pf_win_w;
    logic [31:0] pf_bot_hi_w;
    logic [31:0] pf_top_hi_w;
    logic [31:0] io_hi_w;
    logic [31:0] irq_line_w;

    // type nibbles are outside the write mask and hold zero in storage
    bwcr_wr_reg #(
        .RST_VAL(bwcr_pkg::RST_ZERO),
        .WR_MASK(bwcr_pkg::MASK_PF_WIN)
    ) u_pf_win (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wr_en_i(bus_wr && hit_pf_win),
        .sel_i(wb_sel_i),
        .wdat_i(wb_dat_i),
        .q_o(pf_win_w)
    ); // [R1] [R2] [R3] [R9]

    bwcr_wr_reg #(
        .RST_VAL(bwcr_pkg::RST_ZERO),
        .WR_MASK(bwcr_pkg::MASK_FULL)
    ) u_pf_bot_hi (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wr_en_i(bus_wr && hit_pf_bot_hi),
        .sel_i(wb_sel_i),
        .wdat_i(wb_dat_i),
        .q_o(pf_bot_hi_w)
    ); // [R4] [R9]

    bwcr_wr_reg #(
        .RST_VAL(bwcr_pkg::RST_ZERO),
        .WR_MASK(bwcr_pkg::MASK_FULL)
    ) u_pf_top_hi (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wr_en_i(bus_wr && hit_pf_top_hi),
        .sel_i(wb_sel_i),
        .wdat_i(wb_dat_i),
        .q_o(pf_top_hi_w)
    ); // [R5] [R9]

    bwcr_wr_reg #(
        .RST_VAL(bwcr_pkg::RST_ZERO),
        .WR_MASK(bwcr_pkg::MASK_FULL)
    ) u_io_hi (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wr_en_i(bus_wr && hit_io_hi),
        .sel_i(wb_sel_i),
        .wdat_i(wb_dat_i),
        .q_o(io_hi_w)
    ); // [R7] [R8] [R9]

    // no hardware consumer besides the read view and the output copy
    bwcr_wr_reg #(
        .RST_VAL(bwcr_pkg::RST_ZERO),
        .WR_MASK(bwcr_pkg::MASK_IRQ_LINE)
    ) u_irq_line (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wr_en_i(bus_wr && hit_irq_line),
        .sel_i(wb_sel_i),
        .wdat_i(wb_dat_i),
        .q_o(irq_line_w)
    ); // [R11]

    // ------------------------------------------------------------------
    // read view
    // ------------------------------------------------------------------
    wire [31:0] type_bits = ({28'h0000000, bwcr_pkg::PF_TYPE_64} << bwcr_pkg::PF_TYPE_BOT_LSB)
        | ({28'h0000000, bwcr_pkg::PF_TYPE_64} << bwcr_pkg::PF_TYPE_TOP_LSB);
    wire [31:0] rd_pf_win = pf_win_w | type_bits; // [R1]
    wire [31:0] rd_cap_ptr = {24'h000000, bwcr_pkg::CAP_PTR_VAL}; // [R10]
    wire [31:0] rd_irq_line = irq_line_w; // [R11]

    wire [31:0] rd_mux = hit_pf_win ? rd_pf_win :
        hit_pf_bot_hi ? pf_bot_hi_w :
        hit_pf_top_hi ? pf_top_hi_w :
        hit_io_hi ? io_hi_w :
        hit_cap_ptr ? rd_cap_ptr :
        hit_irq_line ? rd_irq_line :
        bwcr_pkg::RD_UNMAPPED;

    // ------------------------------------------------------------------
    // bus answer
    // ------------------------------------------------------------------
    logic ack_d;
    logic [31:0] rdat_d;

    assign ack_d = bus_start;
    // read data holds between requests, so a late sample still sees it
    assign rdat_d = bus_start ? rd_mux : rdat_q;
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            rdat_q <= bwcr_pkg::RD_UNMAPPED;
        end else begin
            ack_q <= ack_d;
            rdat_q <= rdat_d;
        end
    end

    // ------------------------------------------------------------------
    // window assembly
    // ------------------------------------------------------------------
    wire [11:0] pf_bot_field = pf_win_w[bwcr_pkg::PF_BOT_LSB +: bwcr_pkg::PF_FIELD_W];
    wire [11:0] pf_top_field = pf_win_w[bwcr_pkg::PF_TOP_LSB +: bwcr_pkg::PF_FIELD_W];
    wire [15:0] io_bot_field = io_hi_w[bwcr_pkg::IO_BOT_LSB +: bwcr_pkg::IO_FIELD_W];
    wire [15:0] io_top_field = io_hi_w[bwcr_pkg::IO_TOP_LSB +: bwcr_pkg::IO_FIELD_W];

    wire [63:0] pf_bottom = {pf_bot_hi_w, pf_bot_field, bwcr_pkg::PF_LOW_ZERO}; // [R2] [R4]
    wire [63:0] pf_top = {pf_top_hi_w, pf_top_field, bwcr_pkg::PF_LOW_ONES}; // [R3] [R5]
    wire [31:0] io_bottom = {io_bot_field, io_bot_low_i}; // [R7]
    wire [31:0] io_top = {io_top_field, io_top_low_i}; // [R8]

    // ------------------------------------------------------------------
    // forwarding decode
    // ------------------------------------------------------------------
    logic mem_hit_w;
    logic io_hit_w;

    bwcr_win_cmp #(
        .AW(64)
    ) u_mem_cmp (
        .bottom_i(pf_bottom),
        .top_i(pf_top),
        .addr_i(mem_req_i.addr),
        .hit_o(mem_hit_w)
    ); // [R6] [R12]

    bwcr_win_cmp #(
        .AW(32)
    ) u_io_cmp (
        .bottom_i(io_bottom),
        .top_i(io_top),
        .addr_i(io_req_i.addr),
        .hit_o(io_hit_w)
    ); // [R7] [R8] [R12]

    bwcr_pkg::bwcr_fwd_t mem_fwd_q;
    bwcr_pkg::bwcr_fwd_t mem_fwd_d;
    bwcr_pkg::bwcr_fwd_t io_fwd_q;
    bwcr_pkg::bwcr_fwd_t io_fwd_d;

    assign mem_fwd_d.vld = mem_req_i.vld;
    assign mem_fwd_d.wr = mem_req_i.vld && mem_req_i.wr;
    assign mem_fwd_d.hit = mem_req_i.vld && mem_hit_w; // [R6]
    assign io_fwd_d.vld = io_req_i.vld;
    assign io_fwd_d.wr = io_req_i.vld && io_req_i.wr;
    assign io_fwd_d.hit = io_req_i.vld && io_hit_w; // [R7] [R8]

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mem_fwd_q <= '0;
            io_fwd_q <= '0;
        end else begin
            mem_fwd_q <= mem_fwd_d;
            io_fwd_q <= io_fwd_d;
        end
    end

    assign mem_fwd_o = mem_fwd_q;
    assign io_fwd_o = io_fwd_q;

    // ------------------------------------------------------------------
    // window copies for the rest of the port
    // ------------------------------------------------------------------
    bwcr_pkg::bwcr_pf_win_t pf_win_q;
    bwcr_pkg::bwcr_pf_win_t pf_win_d;
    bwcr_pkg::bwcr_io_win_t io_win_q;
    bwcr_pkg::bwcr_io_win_t io_win_d;
    logic [7:0] irq_line_q;
    logic [7:0] irq_line_d;

    assign pf_win_d.bottom = pf_bottom;
    assign pf_win_d.top = pf_top;
    assign io_win_d.bottom = io_bottom;
    assign io_win_d.top = io_top;
    assign irq_line_d = irq_line_w[bwcr_pkg::IRQ_LINE_W-1:0];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pf_win_q <= {32'h00000000, 12'h000, bwcr_pkg::PF_LOW_ZERO,
                         32'h00000000, 12'h000, bwcr_pkg::PF_LOW_ONES};
            io_win_q <= '0;
            irq_line_q <= 8'h00;
        end else begin
            pf_win_q <= pf_win_d;
            io_win_q <= io_win_d;
            irq_line_q <= irq_line_d;
        end
    end

    assign pf_win_o = pf_win_q;
    assign io_win_o = io_win_q;
    assign irq_line_o = irq_line_q;

endmodule // bwcr_regs

// ==== bwcr_regs_sva.sv ====
// concurrent checks of the bridge window configuration registers
`timescale 1ns/100ps
module bwcr_regs_sva #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // windows and forwarding
    input wire logic [15:0] io_bot_low_i,
    input wire logic [15:0] io_top_low_i,
    input wire bwcr_pkg::bwcr_mem_req_t mem_req_i,
    input wire bwcr_pkg::bwcr_io_req_t io_req_i,
    input wire bwcr_pkg::bwcr_fwd_t mem_fwd_o,
    input wire bwcr_pkg::bwcr_fwd_t io_fwd_o,
    input wire bwcr_pkg::bwcr_pf_win_t pf_win_o,
    input wire bwcr_pkg::bwcr_io_win_t io_win_o,
    input wire logic [7:0] irq_line_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire logic req_c = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire logic rd_c = wb_ack_o && !wb_we_i;
    wire logic wr_c = wb_ack_o && wb_we_i && wb_sel_i == 4'hF;
    wire logic mem_hit_c = pf_win_o.bottom <= mem_req_i.addr && mem_req_i.addr <= pf_win_o.top;
    wire logic [31:0] io_bot_c = {io_win_o.bottom[31:16], io_bot_low_i};
    wire logic [31:0] io_top_c = {io_win_o.top[31:16], io_top_low_i};
    wire logic io_hit_c = io_bot_c <= io_req_i.addr && io_req_i.addr <= io_top_c;
    a_ack_pulse: assert property (req_c |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack is not a one-cycle answer");
    a_type_nibble: assert property (rd_c && wb_adr_i == bwcr_pkg::OFF_PF_WIN |->
        wb_dat_o[3:0] == 4'h1 && wb_dat_o[19:16] == 4'h1) else $error("type nibble wrong");
    a_cap_fixed: assert property (rd_c && wb_adr_i == bwcr_pkg::OFF_CAP_PTR |->
        wb_dat_o == 32'h00000040) else $error("capability offset wrong");
    a_low_fill: assert property (pf_win_o.bottom[19:0] == 20'h00000 &&
        pf_win_o.top[19:0] == 20'hFFFFF) else $error("window low bits wrong");
    a_bottom_join: assert property (wr_c && wb_adr_i == bwcr_pkg::OFF_PF_BOT_HI |->
        ##2 pf_win_o.bottom[63:32] == $past(wb_dat_i, 2)) else $error("bottom high word lost");
    a_io_join: assert property (wr_c && wb_adr_i == bwcr_pkg::OFF_IO_HI |-> ##2
        io_win_o.bottom[31:16] == $past(wb_dat_i[15:0], 2) &&
        io_win_o.top[31:16] == $past(wb_dat_i[31:16], 2)) else $error("io high halves lost");
    a_irq_copy: assert property (wb_ack_o && wb_we_i && wb_sel_i[0] &&
        wb_adr_i == bwcr_pkg::OFF_IRQ_LINE |-> ##2 irq_line_o == $past(wb_dat_i[7:0], 2))
        else $error("interrupt line byte lost");
    a_mem_decide: assert property (mem_req_i.vld && !$past(wb_ack_o) |=>
        mem_fwd_o.vld && mem_fwd_o.wr == $past(mem_req_i.wr) &&
        mem_fwd_o.hit == $past(mem_hit_c)) else $error("memory decision wrong");
    a_io_decide: assert property (io_req_i.vld && !$past(wb_ack_o) |=>
        io_fwd_o.vld && io_fwd_o.wr == $past(io_req_i.wr) &&
        io_fwd_o.hit == $past(io_hit_c)) else $error("io decision wrong");
    a_fwd_quiet: assert property (!mem_req_i.vld && !io_req_i.vld |=>
        !mem_fwd_o.vld && !io_fwd_o.vld) else $error("decision without request");
    c_read: cover property (rd_c);
    c_mem_hit: cover property (mem_fwd_o.vld && mem_fwd_o.hit);
    c_io_miss: cover property (io_fwd_o.vld && !io_fwd_o.hit);
endmodule // bwcr_regs_sva

bind bwcr_regs bwcr_regs_sva #(.ADDR_W(ADDR_W)) bwcr_regs_sva_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .io_bot_low_i(io_bot_low_i),
    .io_top_low_i(io_top_low_i), .mem_req_i(mem_req_i), .io_req_i(io_req_i),
    .mem_fwd_o(mem_fwd_o), .io_fwd_o(io_fwd_o), .pf_win_o(pf_win_o),
    .io_win_o(io_win_o), .irq_line_o(irq_line_o));

// ==== bwcr_regs_bench.sv ====
// self-checking bench of the bridge window configuration registers
`timescale 1ns/100ps
module bwcr_regs_bench;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h00000000;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic [15:0] io_bot_low_i = 16'h0000;
    logic [15:0] io_top_low_i = 16'h0000;
    bwcr_pkg::bwcr_mem_req_t mem_req_i = '0;
    bwcr_pkg::bwcr_io_req_t io_req_i = '0;
    bwcr_pkg::bwcr_fwd_t mem_fwd_o;
    bwcr_pkg::bwcr_fwd_t io_fwd_o;
    bwcr_pkg::bwcr_pf_win_t pf_win_o;
    bwcr_pkg::bwcr_io_win_t io_win_o;
    logic [7:0] irq_line_o;
    logic [31:0] mdl [16];
    logic [31:0] rd_q [$];
    logic [31:0] wq [$];
    logic [1:0] mq [$];
    logic [1:0] iq [$];
    int n_fail = 0;
    int checked = 0;
    always #20 clk_i = ~clk_i;
    bwcr_regs #(.ADDR_W(8)) bwcr_regs_inst (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .io_bot_low_i(io_bot_low_i),
        .io_top_low_i(io_top_low_i), .mem_req_i(mem_req_i), .io_req_i(io_req_i),
        .mem_fwd_o(mem_fwd_o), .io_fwd_o(io_fwd_o), .pf_win_o(pf_win_o),
        .io_win_o(io_win_o), .irq_line_o(irq_line_o));
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic conclude();
        if (n_fail == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // writable bits of each word, zero where unmapped
    function automatic logic [31:0] wmask(input logic [7:0] a);
        case (a)
            8'h24: return bwcr_pkg::MASK_PF_WIN;
            8'h28, 8'h2C, 8'h30: return bwcr_pkg::MASK_FULL;
            8'h3C: return bwcr_pkg::MASK_IRQ_LINE;
            default: return 32'h00000000;
        endcase
    endfunction
    task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] s,
                        input logic [31:0] d);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= d;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1) @(posedge clk_i);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [7:0] a);
        logic [31:0] e;
        e = mdl[a[5:2]] & wmask(a);
        if (a == 8'h24) e = e | 32'h00010001;
        if (a == 8'h34) e = e | 32'h00000040;
        rd_q.push_back(e);
        xfer(1'b0, a, 4'hF, 32'h00000000);
    endtask
    task automatic wr(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
        logic [31:0] m;
        m = wmask(a) & {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
        mdl[a[5:2]] = (mdl[a[5:2]] & ~m) | (d & m);
        xfer(1'b1, a, s, d);
    endtask
    task automatic rd_all();
        for (int a = 8'h20; a <= 8'h40; a += 4) rd(a[7:0]);
    endtask
    task automatic do_reset();
        rst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (mdl[i]) mdl[i] = 32'h00000000;
    endtask
    // one request on each path at a window edge or a random spot
    task automatic probe(input int k);
        logic [63:0] pb;
        logic [63:0] pt;
        logic [63:0] ma;
        logic [31:0] ib;
        logic [31:0] it;
        logic [31:0] ia;
        logic w;
        pb = {mdl[10], mdl[9][15:4], 20'h00000};
        pt = {mdl[11], mdl[9][31:20], 20'hFFFFF};
        ib = {mdl[12][15:0], io_bot_low_i};
        it = {mdl[12][31:16], io_top_low_i};
        case (k)
            0: {ma, ia} = {pb, ib};
            1: {ma, ia} = {pb - 64'h1, ib - 32'h1};
            2: {ma, ia} = {pt, it};
            3: {ma, ia} = {pt + 64'h1, it + 32'h1};
            default: {ma, ia} = {31'h0, 1'($urandom), $urandom,
                    15'h0, 1'($urandom), 16'($urandom)};
        endcase
        w = 1'($urandom);
        mq.push_back({w, pb <= ma && ma <= pt});
        iq.push_back({~w, ib <= ia && ia <= it});
        wq.push_back(pb[63:32]);
        wq.push_back(pb[31:0]);
        wq.push_back(pt[63:32]);
        wq.push_back(pt[31:0]);
        wq.push_back(ib);
        wq.push_back(it);
        wq.push_back({24'h000000, mdl[15][7:0]});
        mem_req_i <= {1'b1, w, ma};
        io_req_i <= {1'b1, ~w, ia};
        @(posedge clk_i);
    endtask
    always @(posedge clk_i) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
            check("read", wb_dat_o, rd_q.pop_front());
        if (rst_i === 1'b0 && mem_fwd_o.vld !== 1'b0) begin
            check("mem_fwd", {30'h0, mem_fwd_o[1:0]}, {30'h0, mq.pop_front()});
            check("pf_bot_hi", pf_win_o.bottom[63:32], wq.pop_front());
            check("pf_bot_lo", pf_win_o.bottom[31:0], wq.pop_front());
            check("pf_top_hi", pf_win_o.top[63:32], wq.pop_front());
            check("pf_top_lo", pf_win_o.top[31:0], wq.pop_front());
        end
        if (rst_i === 1'b0 && io_fwd_o.vld !== 1'b0) begin
            check("io_fwd", {30'h0, io_fwd_o[1:0]}, {30'h0, iq.pop_front()});
            check("io_bottom", io_win_o.bottom, wq.pop_front());
            check("io_top", io_win_o.top, wq.pop_front());
            check("irq_line", {24'h000000, irq_line_o}, wq.pop_front());
        end
    end
    initial begin
        repeat (10000) @(posedge clk_i);
        n_fail++;
        conclude();
    end
    initial begin
        void'($urandom(32'hF68F83CA));
        do_reset();
        rd_all();
        repeat (3) begin
            for (int a = 8'h20; a <= 8'h40; a += 4) wr(a[7:0], 4'($urandom), $urandom);
            rd_all();
        end
        wr(8'h3C, 4'h1, $urandom);
        // high words chosen so that one round inverts each window
        for (int r = 0; r < 4; r++) begin
            io_bot_low_i <= 16'($urandom);
            io_top_low_i <= 16'($urandom);
            wr(8'h24, 4'hF, $urandom);
            wr(8'h28, 4'hF, 32'(r & 1));
            wr(8'h2C, 4'hF, 32'(r >> 1));
            wr(8'h30, 4'hF, {16'(r >> 1), 16'(r & 1)});
            for (int k = 0; k < 7; k++) probe(k);
            mem_req_i <= '0;
            io_req_i <= '0;
            @(posedge clk_i);
        end
        do_reset();
        rd_all();
        repeat (3) @(posedge clk_i);
        conclude();
    end
endmodule // bwcr_regs_bench
